// *** folr_defs.svh ***
/*
 * Constants for the offset load and retransmit block: sizes, reset values,
 * bus-width geometry and cycle counts. Included by every design file but the package.
 */
`ifndef FOLR_DEFS_SVH
`define FOLR_DEFS_SVH

// memory geometry
`define FOLR_DW       36
`define FOLR_AW       16
`define FOLR_DEPTH    17'h10000
`define FOLR_HALF     17'h08000

// offset registers
`define FOLR_OFS_BITS 16
`define FOLR_OFS_RST  36'h0_0000_03ff

// bus width geometry: portion masks and bit steps
`define FOLR_M36      36'hf_ffff_ffff
`define FOLR_M18      36'h0_0003_ffff
`define FOLR_M9       36'h0_0000_01ff
`define FOLR_STEP18   6'h12
`define FOLR_STEP9    6'h09

// width strap codes (anything else means x36)
`define FOLR_SEL_X18  2'h1
`define FOLR_SEL_X9   2'h2

// cycle counts
`define FOLR_RT_SETUP 3'h3
`define FOLR_VLD_LAT  2'h2
`define FOLR_VLD_BAD  2'h3

`endif

// *** folr_host.sv ***
/*
 * Host partner: drives the write and read ports of the FIFO.
 * Assumes one call of drv per mclk cycle from the bench.
 */
`timescale 1ns/1ns
`include "folr_defs.svh"
module folr_host (
	// clock
	input  wire logic                mclk,
	// host controls, active low
	output logic                     write_en_n,
	output logic                     offset_load_select_n,
	output logic                     read_en_n,
	output logic                     retransmit_n,
	// write data
	output logic [`FOLR_DW-1:0]      data_in_bus
);
	// idle at time zero
	initial begin
		write_en_n = 1'h1;
		offset_load_select_n = 1'h1;
		read_en_n = 1'h1;
		retransmit_n = 1'h1;
		data_in_bus = 36'h0;
	end

	// one cycle of requests, set just after the edge
	task automatic drv(input logic wen_n, input logic ld_n, input logic ren_n, input logic rt_n,
		input logic [`FOLR_DW-1:0] d);
		@(posedge mclk);
		write_en_n <= wen_n | !rt_n; // write enable high around retransmit
		offset_load_select_n <= ld_n;
		read_en_n <= ren_n | (!ld_n && !wen_n); // no offset read beside offset write
		retransmit_n <= rt_n;
		// an idle bus never repeats the last word
		data_in_bus <= wen_n ? ~data_in_bus : d;
	endtask
endmodule

// *** folr_ofs_file.sv ***
/*
 * Almost-empty and almost-full offset registers with their own parallel
 * write and read pointers. Assumes master reset on resetn only; partial
 * reset never reaches this module.
 */
`timescale 1ns/1ns
`include "folr_defs.svh"
module folr_ofs_file
	import folr_pkg::*;
(
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// bus widths
	input  folr_bus_w_t                     in_w,
	input  folr_bus_w_t                     out_w,
	// offset write
	input  wire logic                       wr_en,
	input  wire logic [`FOLR_DW-1:0]        wr_data,
	// offset read
	input  wire logic                       rd_en,
	output logic      [`FOLR_DW-1:0]        rd_data,
	// offsets and load events, index 0 empty, 1 full
	output logic      [`FOLR_OFS_BITS-1:0]  empty_ofs,
	output logic      [`FOLR_OFS_BITS-1:0]  full_ofs,
	output logic      [1:0]                 touch,
	output logic      [1:0]                 done
);

	logic [2:0]          np_w, np_r, last_w, last_r;
	logic [2:0]          wp_q, rp_q, wq, rq;
	logic [5:0]          st_w, st_r, sh_w, sh_r;
	logic [`FOLR_DW-1:0] m_w, m_r;
	logic                wsel, rsel;

	// portions per offset, bit step and portion mask for a width
	function automatic logic [44:0] geom(input folr_bus_w_t w);
		unique case (w)
			FOLR_W18: geom = {3'h2, `FOLR_STEP18, `FOLR_M18};
			FOLR_W9:  geom = {3'h3, `FOLR_STEP9, `FOLR_M9};
			default:  geom = {3'h1, 6'h00, `FOLR_M36};
		endcase
	endfunction

	assign {np_w, st_w, m_w} = geom(in_w);
	assign {np_r, st_r, m_r} = geom(out_w);
	assign last_w = {np_w[1:0], 1'b0} - 3'h1;
	assign last_r = {np_r[1:0], 1'b0} - 3'h1;

	// split each pointer into offset select and portion
	assign wsel = (wp_q >= np_w);
	assign rsel = (rp_q >= np_r);
	assign wq   = wsel ? wp_q - np_w : wp_q;
	assign rq   = rsel ? rp_q - np_r : rp_q;
	assign sh_w = st_w * {3'h0, wq};
	assign sh_r = st_r * {3'h0, rq};

	// one register per offset; a write replaces only the selected portion
	for (genvar i = 0; i < 2; i++) begin : g_ofs
		logic [`FOLR_DW-1:0] val_q;
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				val_q <= `FOLR_OFS_RST;
			end else if (wr_en && (wsel == i[0])) begin
				val_q <= (val_q & ~(m_w << sh_w)) | ((wr_data & m_w) << sh_w);
			end
		end
		assign touch[i] = wr_en && (wsel == i[0]);
		assign done[i]  = touch[i] && (wq == np_w - 3'h1);
	end

	assign empty_ofs = g_ofs[0].val_q[`FOLR_OFS_BITS-1:0];
	assign full_ofs  = g_ofs[1].val_q[`FOLR_OFS_BITS-1:0];
	assign rd_data   = ((rsel ? g_ofs[1].val_q : g_ofs[0].val_q) >> sh_r) & m_r;

	// write pointer: empty portions first, then full, then wrap
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wp_q <= 3'h0; // back to empty low portion
		end else if (wr_en) begin
			wp_q <= (wp_q >= last_w) ? 3'h0 : wp_q + 3'h1;
		end
	end

	// read pointer, independent of the write pointer; holds while paused
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rp_q <= 3'h0;
		end else if (rd_en) begin
			rp_q <= (rp_q >= last_r) ? 3'h0 : rp_q + 3'h1;
		end
	end

	property p_wr_wrap;
		@(posedge mclk) disable iff (!resetn)
		wr_en && (wp_q == last_w) |=> (wp_q == 3'h0);
	endproperty
	a_wr_wrap: assert property (p_wr_wrap) else $error("offset write pointer did not wrap");

	property p_wr_hold;
		@(posedge mclk) disable iff (!resetn)
		!wr_en |=> $stable(wp_q);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("offset write pointer moved while paused");

	property p_rd_hold;
		@(posedge mclk) disable iff (!resetn)
		!rd_en ##1 !rd_en |-> $stable(rp_q) && ($past(wr_en) || $stable(wp_q));
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("offset read pointer moved while paused");

endmodule

// *** folr_pkg.sv ***
/*
 * Types shared by the offset load and retransmit block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package folr_pkg;

	// bus width chosen at master reset
	typedef enum logic [1:0] {FOLR_W36, FOLR_W18, FOLR_W9} folr_bus_w_t;

	// retransmit setup sequencer
	typedef enum logic {RT_IDLE, RT_SETUP} folr_rt_st_t;

endpackage

// *** folr_ram.sv ***
/*
 * Storage array of the FIFO: one write port, one combinational read port.
 * Assumes the caller guards writes against a full array.
 */
`timescale 1ns/1ns
`include "folr_defs.svh"
module folr_ram
	import folr_pkg::*;
(
	// clock
	input  wire logic                 mclk,
	// write port
	input  wire logic                 we,
	input  wire logic [`FOLR_AW-1:0]  waddr,
	input  wire logic [`FOLR_DW-1:0]  wdata,
	// read port
	input  wire logic [`FOLR_AW-1:0]  raddr,
	output logic      [`FOLR_DW-1:0]  rdata
);

	logic [`FOLR_DW-1:0] mem_q [0:(1 << `FOLR_AW)-1];

	// no reset: contents are undefined until written
	always_ff @(posedge mclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// read is combinational so a zero-latency load sees it on the same edge
	assign rdata = mem_q[raddr];

endmodule

// *** folr_top.sv ***
/*
 * Synchronous FIFO with parallel offset loading and reading over the data
 * buses and normal or zero latency retransmit. Write and read ports share
 * mclk; the host is clocked logic on the same clock.
 */
`timescale 1ns/1ns
`include "folr_defs.svh"
module folr_top
	import folr_pkg::*;
(
	// clock and resets
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	input  wire logic                 partial_reset_n,
	// straps, sampled at the first edge after master reset
	input  wire logic                 fall_through_select,
	input  wire logic                 retransmit_latency_select,
	input  wire logic                 parallel_program_select,
	input  wire logic [1:0]           in_width_sel,
	input  wire logic [1:0]           out_width_sel,
	// write port
	input  wire logic                 write_en_n,
	input  wire logic                 offset_load_select_n,
	input  wire logic [`FOLR_DW-1:0]  data_in_bus,
	// read port
	input  wire logic                 read_en_n,
	input  wire logic                 retransmit_n,
	output logic      [`FOLR_DW-1:0]  data_out_bus,
	// status flags, all active low
	output logic                      empty_flag_n,
	output logic                      full_flag_n,
	output logic                      output_ready_n,
	output logic                      input_ready_n,
	output logic                      half_full_flag_n,
	output logic                      almost_empty_flag_n,
	output logic                      almost_full_flag_n
);

	logic                      take_q, fall_through_mode_q, zlat_q, par_q;
	folr_bus_w_t               in_w_q, out_w_q;
	logic [`FOLR_AW:0]         wptr_q, rptr_q, count, rptr_d, count_d;
	folr_rt_st_t               st_q;
	logic [2:0]                rt_cnt_q;
	logic                      prst, full, ofs_wr, ofs_rd, mem_we, rt_go, setup_end, fetch;
	logic                      ae_raw, af_raw, hf_raw, ae_s_q, af_s_q, ae_ok, af_ok;
	logic [`FOLR_AW-1:0]       raddr;
	logic [`FOLR_DW-1:0]       ram_rdata, ofs_rd_data;
	logic [`FOLR_OFS_BITS-1:0] empty_ofs, full_ofs;
	logic [1:0]                touch, done;

	// strap code to width
	function automatic folr_bus_w_t dec_w(input logic [1:0] s);
		unique case (s)
			`FOLR_SEL_X18: dec_w = FOLR_W18;
			`FOLR_SEL_X9:  dec_w = FOLR_W9;
			default:       dec_w = FOLR_W36;
		endcase
	endfunction

	// straps caught once after master reset; later pin changes are ignored
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			take_q  <= 1'b1;
			fall_through_mode_q  <= 1'b0;
			zlat_q  <= 1'b0;
			par_q   <= 1'b1;
			in_w_q  <= FOLR_W36;
			out_w_q <= FOLR_W36;
		end else if (take_q) begin
			take_q  <= 1'b0;
			fall_through_mode_q  <= fall_through_select;
			zlat_q  <= retransmit_latency_select;
			par_q   <= parallel_program_select;
			in_w_q  <= dec_w(in_width_sel);
			out_w_q <= dec_w(out_width_sel);
		end
	end

	// partial reset acts on the clock, unlike master reset
	assign prst  = !partial_reset_n;
	assign count = wptr_q - rptr_q;
	assign full  = (count == `FOLR_DEPTH);

	// load select steers a write edge to the offsets or to memory
	assign ofs_wr = !offset_load_select_n && !write_en_n && par_q && !take_q;
	assign mem_we = offset_load_select_n && !write_en_n && !full && !take_q && !prst;

	// retransmit taken only from idle; setup blocks reads until done
	assign rt_go     = !retransmit_n && (st_q == RT_IDLE) && !take_q && !prst;
	assign setup_end = (st_q == RT_SETUP) && (rt_cnt_q == 3'h1);

	// offset read has no mode condition: allowed in both timing modes
	assign ofs_rd = !offset_load_select_n && !read_en_n && (st_q == RT_IDLE) && !rt_go && !prst && !take_q;

	// memory fetch into the output register
	always_comb begin
		fetch = 1'b0;
		if (rt_go || (st_q != RT_IDLE) || !offset_load_select_n || prst || take_q) begin
			fetch = 1'b0;
		end else if (fall_through_mode_q) begin
			fetch = (output_ready_n || !read_en_n) && (count != 0);
		end else begin
			fetch = !read_en_n && (count != 0);
		end
	end

	// first location is addressed on the retransmit edges
	assign raddr = (rt_go || setup_end) ? '0 : rptr_q[`FOLR_AW-1:0];

	folr_ram u_ram (
		.mclk  (mclk),
		.we    (mem_we),
		.waddr (wptr_q[`FOLR_AW-1:0]),
		.wdata (data_in_bus),
		.raddr (raddr),
		.rdata (ram_rdata)
	);

	folr_ofs_file u_ofs (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_w      (in_w_q),
		.out_w     (out_w_q),
		.wr_en     (ofs_wr),
		.wr_data   (data_in_bus),
		.rd_en     (ofs_rd),
		.rd_data   (ofs_rd_data),
		.empty_ofs (empty_ofs),
		.full_ofs  (full_ofs),
		.touch     (touch),
		.done      (done)
	);

	// write pointer; offset edges leave it alone
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wptr_q <= '0;
		end else if (prst) begin
			wptr_q <= '0;
		end else if (mem_we) begin
			wptr_q <= wptr_q + 1'b1;
		end
	end

	// retransmit setup sequencer; zero latency needs no setup window
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_q     <= RT_IDLE;
			rt_cnt_q <= 3'h0;
		end else if (prst) begin
			st_q     <= RT_IDLE;
			rt_cnt_q <= 3'h0;
		end else begin
			unique case (st_q)
				RT_IDLE: begin
					if (rt_go && !zlat_q) begin
						st_q     <= RT_SETUP;
						rt_cnt_q <= `FOLR_RT_SETUP;
					end
				end
				RT_SETUP: begin
					rt_cnt_q <= rt_cnt_q - 3'h1;
					if (setup_end) begin
						st_q <= RT_IDLE;
					end
				end
			endcase
		end
	end

	// read pointer, output register and output-ready, one owner for all three
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rptr_q         <= '0;
			data_out_bus   <= '0;
			output_ready_n <= 1'b1;
		end else if (prst) begin
			rptr_q         <= '0;
			data_out_bus   <= '0;
			output_ready_n <= 1'b1;
		end else if (rt_go) begin
			// pointer home; zero latency already holds word 0
			rptr_q         <= zlat_q ? {{`FOLR_AW{1'b0}}, 1'b1} : '0;
			output_ready_n <= !(zlat_q && fall_through_mode_q);
			if (zlat_q) begin
				data_out_bus <= ram_rdata;
			end
		end else if (setup_end && fall_through_mode_q) begin
			// first word falls through without read enable
			rptr_q         <= {{`FOLR_AW{1'b0}}, 1'b1};
			data_out_bus   <= ram_rdata;
			output_ready_n <= 1'b0;
		end else if (ofs_rd) begin
			data_out_bus <= ofs_rd_data; // old word is lost
		end else if (fetch) begin
			rptr_q         <= rptr_q + 1'b1;
			data_out_bus   <= ram_rdata;
			output_ready_n <= !fall_through_mode_q;
		end else if (fall_through_mode_q && !read_en_n && offset_load_select_n && (st_q == RT_IDLE)) begin
			output_ready_n <= 1'b1; // last word taken, nothing behind it
		end
	end

	// raw thresholds from the live count
	assign ae_raw = (count <= {1'b0, empty_ofs});
	assign af_raw = (count >= (`FOLR_DEPTH - {1'b0, full_ofs}));
	// half-full looks at the count after this edge, so it moves on the edge that moves it
	assign rptr_d  = rt_go ? (zlat_q ? {{`FOLR_AW{1'b0}}, 1'b1} : '0) :
		(setup_end && fall_through_mode_q) ? {{`FOLR_AW{1'b0}}, 1'b1} :
		(fetch && !ofs_rd) ? rptr_q + 1'b1 : rptr_q;
	assign count_d = wptr_q + {{`FOLR_AW{1'b0}}, mem_we} - rptr_d;
	assign hf_raw  = (count_d > `FOLR_HALF);

	// per-flag validity: bad while loading, then a two-edge countdown
	for (genvar i = 0; i < 2; i++) begin : g_vld
		logic [1:0] cnt_q;
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				cnt_q <= 2'h0;
			end else if (done[i]) begin
				cnt_q <= `FOLR_VLD_LAT;
			end else if (touch[i]) begin
				cnt_q <= `FOLR_VLD_BAD;
			end else if ((cnt_q != 2'h0) && (cnt_q != `FOLR_VLD_BAD)) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end

	// frozen from the first loading edge on; valid again two edges after the last portion
	assign ae_ok = (g_vld[0].cnt_q < `FOLR_VLD_LAT) && !touch[0];
	assign af_ok = (g_vld[1].cnt_q < `FOLR_VLD_LAT) && !touch[1];

	// main flags; the unused pair of the other timing mode rests high
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			empty_flag_n     <= 1'b0;
			full_flag_n      <= 1'b1;
			input_ready_n    <= 1'b1;
			half_full_flag_n <= 1'b1;
		end else if (prst || take_q) begin
			// the strap edge already shows the levels of the mode being caught
			empty_flag_n     <= take_q ? fall_through_select : fall_through_mode_q;
			full_flag_n      <= 1'b1;
			input_ready_n    <= take_q ? !fall_through_select : !fall_through_mode_q;
			half_full_flag_n <= 1'b1;
		end else begin
			// empty held low through retransmit setup
			empty_flag_n     <= fall_through_mode_q || ((count != 0) && (st_q == RT_IDLE) && !(rt_go && !zlat_q));
			full_flag_n      <= fall_through_mode_q || !full;
			input_ready_n    <= !fall_through_mode_q || full;
			half_full_flag_n <= !hf_raw; // follows the count on the edge that moves it
		end
	end

	// almost flags: a compare stage and an output stage, so two edges
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ae_s_q              <= 1'b1;
			af_s_q              <= 1'b0;
			almost_empty_flag_n <= 1'b0;
			almost_full_flag_n  <= 1'b1;
		end else if (prst) begin
			ae_s_q              <= 1'b1;
			af_s_q              <= 1'b0;
			almost_empty_flag_n <= 1'b0;
			almost_full_flag_n  <= 1'b1;
		end else begin
			ae_s_q <= ae_raw;
			af_s_q <= af_raw;
			// a flag whose offset is half loaded keeps its last level
			if (ae_ok) begin
				almost_empty_flag_n <= !ae_s_q;
			end
			if (af_ok) begin
				almost_full_flag_n <= !af_s_q;
			end
		end
	end

	property p_ofs_no_mem;
		@(posedge mclk) disable iff (!resetn || prst)
		ofs_wr |=> (wptr_q == $past(wptr_q));
	endproperty
	a_ofs_no_mem: assert property (p_ofs_no_mem) else $error("offset write moved the memory pointer");

	property p_ofs_rd_out;
		@(posedge mclk) disable iff (!resetn || prst)
		ofs_rd |=> (data_out_bus == $past(ofs_rd_data)) && $stable(rptr_q);
	endproperty
	a_ofs_rd_out: assert property (p_ofs_rd_out) else $error("offset read did not reach the output bus");

	property p_rt_home;
		@(posedge mclk) disable iff (!resetn || prst)
		rt_go && !zlat_q |=> (rptr_q == '0) && (st_q == RT_SETUP);
	endproperty
	a_rt_home: assert property (p_rt_home) else $error("retransmit did not home the read pointer");

	property p_rt_empty;
		@(posedge mclk) disable iff (!resetn || prst)
		rt_go && !fall_through_mode_q && !zlat_q && (wptr_q > 17'h1)
			|=> !empty_flag_n[*4] ##1 empty_flag_n;
	endproperty
	a_rt_empty: assert property (p_rt_empty) else $error("empty flag wrong around retransmit setup");

	property p_rt_ready;
		@(posedge mclk) disable iff (!resetn || prst)
		rt_go && fall_through_mode_q && !zlat_q |=> output_ready_n[*3] ##1 !output_ready_n;
	endproperty
	a_rt_ready: assert property (p_rt_ready) else $error("output ready wrong around retransmit setup");

	property p_zlat_load;
		@(posedge mclk) disable iff (!resetn || prst)
		rt_go && zlat_q |=> (data_out_bus == $past(ram_rdata)) && (rptr_q == 17'h1) && (st_q == RT_IDLE);
	endproperty
	a_zlat_load: assert property (p_zlat_load) else $error("zero latency first word not loaded");

	property p_ae_lat;
		@(posedge mclk) disable iff (!resetn || prst)
		$past(ae_ok) && $past(partial_reset_n) && $past(partial_reset_n, 2) && $past(resetn, 2)
			|-> (almost_empty_flag_n == !$past(ae_raw, 2));
	endproperty
	a_ae_lat: assert property (p_ae_lat) else $error("almost empty not two edges behind the count");

	property p_mode_hold;
		@(posedge mclk) disable iff (!resetn)
		!take_q |=> $stable(fall_through_mode_q) && $stable(zlat_q) && $stable(par_q);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after master reset");

	property p_af_bad;
		@(posedge mclk) disable iff (!resetn || prst)
		touch[1] && !done[1] |=> $stable(almost_full_flag_n);
	endproperty
	a_af_bad: assert property (p_af_bad) else $error("almost full moved while its offset loads");

endmodule

// *** tb.sv ***
/*
 * Self-checking bench for the offset load and retransmit FIFO.
 * Assumes one mclk domain; straps are set by master reset.
 */
`timescale 1ns/1ns
`include "folr_defs.svh"
module tb;
	// clock, resets and straps
	logic                 mclk;
	logic                 resetn;
	logic                 partial_reset_n;
	logic                 fall_through_select;
	logic                 retransmit_latency_select;
	logic                 parallel_program_select;
	logic [1:0]           in_width_sel;
	logic [1:0]           out_width_sel;
	// host ports and outputs
	logic                 write_en_n;
	logic                 offset_load_select_n;
	logic                 read_en_n;
	logic                 retransmit_n;
	logic [35:0]          data_in_bus;
	logic [35:0]          data_out_bus;
	logic                 empty_flag_n;
	logic                 full_flag_n;
	logic                 output_ready_n;
	logic                 input_ready_n;
	logic                 half_full_flag_n;
	logic                 almost_empty_flag_n;
	logic                 almost_full_flag_n;
	int                   miscompares;
	int                   check_count;
	localparam logic [35:0] WB = 36'hc_0000_0a00;

	folr_host folr_host_inst (.mclk, .write_en_n, .offset_load_select_n, .read_en_n, .retransmit_n,
		.data_in_bus);
	folr_top folr_top_inst (.mclk, .resetn, .partial_reset_n, .fall_through_select,
		.retransmit_latency_select, .parallel_program_select, .in_width_sel, .out_width_sel,
		.write_en_n, .offset_load_select_n, .data_in_bus, .read_en_n, .retransmit_n, .data_out_bus,
		.empty_flag_n, .full_flag_n, .output_ready_n, .input_ready_n, .half_full_flag_n,
		.almost_empty_flag_n, .almost_full_flag_n);

	// 50 MHz clock
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end

	// compare and count
	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// straps held through a 5 cycle master reset
	task automatic mrst(input logic fts, input logic rls, input logic pps, input logic [1:0] iw,
		input logic [1:0] ow);
		@(posedge mclk);
		resetn <= 1'h0;
		fall_through_select <= fts;
		retransmit_latency_select <= rls;
		parallel_program_select <= pps;
		in_width_sel <= iw;
		out_width_sel <= ow;
		repeat (5) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
	endtask

	// bus cycle helpers
	task automatic idle();
		folr_host_inst.drv(1'h1, 1'h1, 1'h1, 1'h1, 36'h0);
	endtask
	task automatic owr(input logic [35:0] d);
		folr_host_inst.drv(1'h0, 1'h0, 1'h1, 1'h1, d);
		idle();
	endtask
	task automatic orc(input logic [35:0] exp);
		folr_host_inst.drv(1'h1, 1'h0, 1'h0, 1'h1, 36'h0);
		idle();
		#2 chk("offset portion", exp, data_out_bus);
	endtask
	task automatic mw(input logic [35:0] d);
		folr_host_inst.drv(1'h0, 1'h1, 1'h1, 1'h1, d);
		idle();
	endtask
	task automatic mrc(input logic [35:0] exp);
		folr_host_inst.drv(1'h1, 1'h1, 1'h0, 1'h1, 36'h0);
		idle();
		#2 chk("read word", exp, data_out_bus);
	endtask
	task automatic rt();
		folr_host_inst.drv(1'h1, 1'h1, 1'h1, 1'h0, 36'h0);
		idle();
		#2;
	endtask
	// four words written, then read or consumed by the caller: count stays legal
	task automatic fill4();
		for (int i = 0; i < 4; i++) mw(WB + 36'(i));
	endtask

	task automatic t_x36();
		mrst(1'h0, 1'h0, 1'h1, 2'h0, 2'h0);
		owr(36'h1111);
		owr(36'h2222);
		owr(36'h0333);
		#2 chk("empty flag", 36'h0, 36'(empty_flag_n));
		orc(36'h0333);
		orc(36'h2222);
		orc(36'h0333);
		@(posedge mclk);
		partial_reset_n <= 1'h0;
		@(posedge mclk);
		partial_reset_n <= 1'h1;
		owr(36'h0444);
		orc(36'h0444);
		orc(36'h0333);
		$display("test x36 offsets done");
	endtask

	task automatic t_rt_std();
		fill4();
		mrc(WB);
		mrc(WB + 36'h1);
		chk("empty flag", 36'h1, 36'(empty_flag_n));
		chk("full flag", 36'h1, 36'(full_flag_n));
		rt();
		chk("setup empty", 36'h0, 36'(empty_flag_n));
		repeat (3) @(posedge mclk);
		#2 chk("setup empty", 36'h0, 36'(empty_flag_n));
		@(posedge mclk);
		#2 chk("setup empty", 36'h1, 36'(empty_flag_n));
		mrc(WB);
		$display("test standard retransmit done");
	endtask

	task automatic t_x18_in();
		const logic [35:0] ex [7] = '{36'h11, 36'h0, 36'h0, 36'h34, 36'h9, 36'h0, 36'h11};
		mrst(1'h0, 1'h0, 1'h1, 2'h1, 2'h2);
		owr(36'h0abc);
		owr(36'h0);
		owr(36'h1234);
		owr(36'h0);
		owr(36'h0011);
		owr(36'h0); // empty offset complete again
		foreach (ex[i]) orc(ex[i]);
		repeat (18) mw(WB);
		@(posedge mclk);
		#2 chk("almost empty", 36'h0, 36'(almost_empty_flag_n));
		@(posedge mclk);
		#2 chk("almost empty", 36'h1, 36'(almost_empty_flag_n));
		chk("half full", 36'h1, 36'(half_full_flag_n));
		chk("almost full", 36'h1, 36'(almost_full_flag_n));
		$display("test x18 in x9 out done");
	endtask

	task automatic t_x9_in();
		mrst(1'h0, 1'h0, 1'h1, 2'h2, 2'h1);
		owr(36'h0cd);
		owr(36'h05a);
		mw(36'habcd01234);
		folr_host_inst.drv(1'h1, 1'h0, 1'h1, 1'h1, 36'h0);
		owr(36'h0);
		owr(36'h111);
		owr(36'h022);
		owr(36'h0);
		orc(36'hb4cd);
		mrc(36'habcd01234);
		orc(36'h0);
		orc(36'h4511);
		orc(36'h0);
		$display("test x9 in x18 out done");
	endtask

	task automatic t_fall_through_mode();
		mrst(1'h1, 1'h0, 1'h1, 2'h0, 2'h0);
		#2 chk("empty flag", 36'h1, 36'(empty_flag_n));
		chk("input ready", 36'h0, 36'(input_ready_n));
		orc(36'h3ff);
		fill4();
		#2 chk("ready", 36'h0, 36'(output_ready_n));
		chk("first word", WB, data_out_bus);
		mrc(WB + 36'h1);
		mrc(WB + 36'h2);
		rt();
		chk("setup ready", 36'h1, 36'(output_ready_n));
		repeat (2) @(posedge mclk);
		#2 chk("setup ready", 36'h1, 36'(output_ready_n));
		@(posedge mclk);
		#2 chk("ready", 36'h0, 36'(output_ready_n));
		chk("first word", WB, data_out_bus);
		mrc(WB + 36'h1);
		$display("test fall through retransmit done");
	endtask

	task automatic t_zero();
		mrst(1'h0, 1'h1, 1'h0, 2'h0, 2'h0);
		owr(36'h0055);
		#2 chk("empty flag", 36'h0, 36'(empty_flag_n));
		orc(36'h3ff);
		fill4();
		mrc(WB);
		mrc(WB + 36'h1);
		rt();
		chk("zero latency word", WB, data_out_bus);
		mrc(WB + 36'h1);
		$display("test zero latency retransmit done");
	endtask

	// main sequence
	initial begin
		miscompares = 0;
		check_count = 0;
		resetn = 1'h0;
		partial_reset_n = 1'h1;
		fall_through_select = 1'h0;
		retransmit_latency_select = 1'h0;
		parallel_program_select = 1'h1;
		in_width_sel = 2'h0;
		out_width_sel = 2'h0;
		t_x36();
		t_rt_std();
		t_x18_in();
		t_x9_in();
		t_fall_through_mode();
		t_zero();
		end_sim();
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
